// >>> logic/gpio_defs.svh
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define NUM_PINS 23
// port register blocks: input, direction, output value in that order
`define ADDR_PIN_B 8'h23
`define ADDR_OUT_B 8'h25
`define ADDR_PIN_C 8'h26
`define ADDR_OUT_C 8'h28
`define ADDR_PIN_D 8'h29
`define ADDR_OUT_D 8'h2b
`define KIND_PIN 2'h0
`define KIND_DIR 2'h1
`define KIND_OUT 2'h2
`define PORT_NONE 2'h3
`define ADDR_MCU_CTRL 8'h55
`define ADDR_CHG_CTRL 8'h68
`define ADDR_MASK0 8'h6b
`define ADDR_MASK1 8'h6c
`define ADDR_MASK2 8'h6d
`define PUD_POS 4
`define CHG_CTRL_BITS 8'h07
`define IMPL_FULL 8'hff
`define IMPL_SEVEN 8'h7f
`define RST_BYTE 8'h00
`define G1_LO 8
`define G2_LO 15

`endif

// >>> logic/gpio_pkg.sv
package gpio_pkg;

	typedef enum logic [1:0] {
		OP_BYTE = 2'b00,
		OP_SET = 2'b01,
		OP_CLR = 2'b10
	} bit_op_e;

	typedef logic [7:0] byte_t;
	typedef logic [22:0] pins_t;

	typedef struct packed {
		logic wr;
		logic rd;
		bit_op_e op;
		byte_t addr;
		byte_t wdata;
	} bus_req_s;

	typedef struct packed {
		pins_t en;
		pins_t out;
		pins_t oe;
	} alt_ovr_s;

endpackage : gpio_pkg

// >>> logic/gpio_pin_sync.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_pin_sync import gpio_pkg::*; (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, active high
	input wire pins_t pad_in, // raw pin levels
	input wire logic sleep_clamp, // forces inputs low
	output pins_t pin_val, // synchronised pin levels
	output pins_t changed // level differs from previous cycle
);
	pins_t meta;
	pins_t prev;
	logic primed;

	// clamp ahead of the first stage so floating pins cost nothing
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= '0;
			pin_val <= '0;
		end else begin
			meta <= pad_in & ~{`NUM_PINS{sleep_clamp}};
			pin_val <= meta;
		end
	end

	// no change is reported in the first cycle after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			prev <= '0;
			primed <= 1'b0;
		end else begin
			prev <= pin_val;
			primed <= 1'b1;
		end
	end

	assign changed = primed ? (pin_val ^ prev) : '0;

endmodule : gpio_pin_sync

// >>> logic/gpio_port_top.sv
// Functional notes
// - group-2 mask bit plus group-2 enable lets its pin request.
// - group-1 mask has bits 6..0 only; bit 7 reads zero.
// - group-0 mask bit plus group-0 enable lets its pin request.
// - single-bit set and clear touch only the addressed bit.
// - each port has output, direction and read-only input registers.
// - writing one to an input bit inverts the output bit.
// - global pull-up disable turns off every pull-up.
// - alternate function on a pin leaves other pins unchanged.
// - each pin uses same bit position in its three registers.
// - direction one is output, zero is input.
// - input with output bit one has pull-up; otherwise off.
// - reset tri-states every pin at once.
// - output pin drives its output-value bit.
// - strobes shared per port; clock, clamp, disable shared by all.
// - enabled group raises request on any masked pin change.
// - pin input passes a two-stage synchroniser before reading.
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_port_top import gpio_pkg::*; (
	input wire logic clk, // 100 MHz system clock
	input wire logic srst, // sync reset, active high
	input wire bus_req_s bus, // register access request
	output byte_t rdata, // read data, cycle after read strobe
	input wire pins_t pad_in, // pin levels from the pads
	input wire logic sleep_clamp, // sleep controller input clamp
	input wire alt_ovr_s alt, // alternate function overrides
	output pins_t pad_out, // pin drive level
	output pins_t pad_oe, // pin drive enable
	output pins_t pad_pullup, // pull-up enable
	output logic [2:0] pc_req // per-group pin change request pulse
);
	logic [2:0][7:0] dir_all;
	logic [2:0][7:0] out_all;
	byte_t mask0;
	byte_t mask1;
	byte_t mask2;
	logic [2:0] chg_en;
	logic global_pullup_disable;
	pins_t pin_val;
	pins_t changed;
	pins_t dir_pins;
	pins_t out_pins;
	pins_t oe_q;
	pins_t drv_q;
	pins_t pu_q;
	logic [1:0] wr_port;
	logic [1:0] wr_kind;
	byte_t next_rdata;
	byte_t mcu_wr;

	function automatic logic [1:0] port_of(input byte_t a);
		if (a >= `ADDR_PIN_B && a <= `ADDR_OUT_B) begin
			return 2'h0;
		end else if (a >= `ADDR_PIN_C && a <= `ADDR_OUT_C) begin
			return 2'h1;
		end else if (a >= `ADDR_PIN_D && a <= `ADDR_OUT_D) begin
			return 2'h2;
		end else begin
			return `PORT_NONE;
		end
	endfunction : port_of

	function automatic logic [1:0] kind_of(input byte_t a);
		byte_t rel;
		rel = `RST_BYTE;
		if (a >= `ADDR_PIN_D) begin
			rel = a - `ADDR_PIN_D;
		end else if (a >= `ADDR_PIN_C) begin
			rel = a - `ADDR_PIN_C;
		end else begin
			rel = a - `ADDR_PIN_B;
		end
		return rel[1:0];
	endfunction : kind_of

	function automatic byte_t onehot(input byte_t wd);
		return byte_t'(8'h01 << wd[2:0]);
	endfunction : onehot

	function automatic byte_t apply_op(input byte_t old, input bit_op_e op,
			input byte_t wd);
		if (op == OP_SET) begin
			return old | onehot(wd);
		end else if (op == OP_CLR) begin
			return old & ~onehot(wd);
		end else begin
			return wd;
		end
	endfunction : apply_op

	assign wr_port = port_of(bus.addr);
	assign wr_kind = kind_of(bus.addr);

	// one shared strobe decode per port, per-bit storage below
	for (genvar p = 0; p < 3; p++) begin : g_port
		localparam byte_t IMPL = (p == 1) ? `IMPL_SEVEN : `IMPL_FULL;
		byte_t dir_r;
		byte_t out_r;
		logic hit;
		byte_t toggle;

		assign hit = bus.wr && (wr_port == 2'(p));
		// clearing a bit of the input register writes a zero: no effect
		assign toggle = (bus.op == OP_BYTE) ? bus.wdata :
			(bus.op == OP_SET) ? onehot(bus.wdata) : `RST_BYTE;

		always_ff @(posedge clk) begin
			if (srst) begin
				dir_r <= `RST_BYTE;
			end else if (hit && wr_kind == `KIND_DIR) begin
				dir_r <= apply_op(dir_r, bus.op, bus.wdata) & IMPL;
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				out_r <= `RST_BYTE;
			end else if (hit && wr_kind == `KIND_OUT) begin
				out_r <= apply_op(out_r, bus.op, bus.wdata) & IMPL;
			end else if (hit && wr_kind == `KIND_PIN) begin
				out_r <= (out_r ^ toggle) & IMPL;
			end
		end

		assign dir_all[p] = dir_r;
		assign out_all[p] = out_r;
	end

	// same bit index in each register controls one pin
	assign dir_pins = {dir_all[2], dir_all[1][6:0], dir_all[0]};
	assign out_pins = {out_all[2], out_all[1][6:0], out_all[0]};

	always_ff @(posedge clk) begin
		if (srst) begin
			mask0 <= `RST_BYTE;
			mask1 <= `RST_BYTE;
			mask2 <= `RST_BYTE;
		end else if (bus.wr && bus.addr == `ADDR_MASK0) begin
			mask0 <= apply_op(mask0, bus.op, bus.wdata);
		end else if (bus.wr && bus.addr == `ADDR_MASK1) begin
			mask1 <= apply_op(mask1, bus.op, bus.wdata) & `IMPL_SEVEN;
		end else if (bus.wr && bus.addr == `ADDR_MASK2) begin
			mask2 <= apply_op(mask2, bus.op, bus.wdata);
		end
	end

	// mcu control holds only the disable; other bits are not stored
	assign mcu_wr = apply_op(byte_t'(global_pullup_disable) << `PUD_POS, bus.op, bus.wdata);

	always_ff @(posedge clk) begin
		if (srst) begin
			chg_en <= 3'h0;
			global_pullup_disable <= 1'b0;
		end else if (bus.wr && bus.addr == `ADDR_CHG_CTRL) begin
			chg_en <= 3'(apply_op(byte_t'(chg_en), bus.op, bus.wdata));
		end else if (bus.wr && bus.addr == `ADDR_MCU_CTRL) begin
			global_pullup_disable <= mcu_wr[`PUD_POS];
		end
	end

	// per-pin muxing only, so an override never reaches a neighbour
	always_ff @(posedge clk) begin
		if (srst) begin
			oe_q <= '0;
			drv_q <= '0;
			pu_q <= '0;
		end else begin
			oe_q <= (alt.en & alt.oe) | (~alt.en & dir_pins);
			drv_q <= (alt.en & alt.out) | (~alt.en & out_pins);
			pu_q <= ~alt.en & ~dir_pins & out_pins
				& ~{`NUM_PINS{global_pullup_disable}};
		end
	end

	// reset gates the pads directly so pins float without a clock edge
	assign pad_oe = oe_q & ~{`NUM_PINS{srst}};
	assign pad_pullup = pu_q & ~{`NUM_PINS{srst}};
	assign pad_out = drv_q;

	gpio_pin_sync u_sync (
		.clk(clk),
		.srst(srst),
		.pad_in(pad_in),
		.sleep_clamp(sleep_clamp),
		.pin_val(pin_val),
		.changed(changed)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			pc_req <= 3'h0;
		end else begin
			pc_req[0] <= chg_en[0] && |(changed[7:0] & mask0);
			pc_req[1] <= chg_en[1]
				&& |(changed[`G1_LO +: 7] & mask1[6:0]);
			pc_req[2] <= chg_en[2]
				&& |(changed[`G2_LO +: 8] & mask2);
		end
	end

	always_comb begin
		next_rdata = `RST_BYTE;
		if (wr_port == 2'h0 && wr_kind == `KIND_PIN) begin
			next_rdata = pin_val[7:0];
		end else if (wr_port == 2'h1 && wr_kind == `KIND_PIN) begin
			next_rdata = {1'b0, pin_val[`G1_LO +: 7]};
		end else if (wr_port == 2'h2 && wr_kind == `KIND_PIN) begin
			next_rdata = pin_val[`G2_LO +: 8];
		end else if (wr_port != `PORT_NONE && wr_kind == `KIND_DIR) begin
			next_rdata = dir_all[wr_port];
		end else if (wr_port != `PORT_NONE && wr_kind == `KIND_OUT) begin
			next_rdata = out_all[wr_port];
		end else if (bus.addr == `ADDR_MASK0) begin
			next_rdata = mask0;
		end else if (bus.addr == `ADDR_MASK1) begin
			next_rdata = mask1;
		end else if (bus.addr == `ADDR_MASK2) begin
			next_rdata = mask2;
		end else if (bus.addr == `ADDR_CHG_CTRL) begin
			next_rdata = byte_t'(chg_en) & `CHG_CTRL_BITS;
		end else if (bus.addr == `ADDR_MCU_CTRL) begin
			next_rdata = byte_t'(global_pullup_disable) << `PUD_POS;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= `RST_BYTE;
		end else begin
			rdata <= bus.rd ? next_rdata : `RST_BYTE;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_grp2_gate;
		pc_req[2] |-> $past(chg_en[2] && |(changed[`G2_LO +: 8] & mask2));
	endproperty
	a_grp2_gate: assert property (p_grp2_gate)
		else $error("group 2 request without enabled change");

	property p_grp1_top;
		rdata[7] == 1'b0 || !$past(bus.rd && bus.addr == `ADDR_MASK1);
	endproperty
	a_grp1_top: assert property (p_grp1_top)
		else $error("group 1 mask bit 7 reads one");

	property p_grp0_gate;
		pc_req[0] |-> $past(chg_en[0] && |(changed[7:0] & mask0));
	endproperty
	a_grp0_gate: assert property (p_grp0_gate)
		else $error("group 0 request without enabled change");

	property p_bit_set_dir;
		(bus.wr && bus.op == OP_SET && bus.addr == `ADDR_PIN_B + 8'h01)
			|=> dir_all[0] == ($past(dir_all[0]) | onehot($past(bus.wdata)));
	endproperty
	a_bit_set_dir: assert property (p_bit_set_dir)
		else $error("bit set disturbed other direction bits");

	property p_toggle;
		(bus.wr && bus.op == OP_BYTE && bus.addr == `ADDR_PIN_B)
			|=> out_all[0] == ($past(out_all[0]) ^ $past(bus.wdata));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("input register write did not toggle outputs");

	property p_pud_off;
		$past(global_pullup_disable) |-> pad_pullup == '0;
	endproperty
	a_pud_off: assert property (p_pud_off)
		else $error("pull-up on while globally disabled");

	property p_drive;
		!alt.en[0] && dir_pins[0] |=> pad_oe[0] && pad_out[0] == $past(out_pins[0]);
	endproperty
	a_drive: assert property (p_drive)
		else $error("output pin not driving its value");

	property p_pullup;
		!alt.en[1] && !global_pullup_disable |=> pad_pullup[1] == $past(!dir_pins[1] && out_pins[1]);
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up state wrong");

	property p_rst_float;
		@(posedge clk) disable iff (1'b0)
		srst |-> pad_oe == '0 && pad_pullup == '0;
	endproperty
	a_rst_float: assert property (p_rst_float)
		else $error("pin driven during reset");

	property p_change_req;
		chg_en[2] && |(changed[`G2_LO +: 8] & mask2) |=> pc_req[2];
	endproperty
	a_change_req: assert property (p_change_req)
		else $error("masked change missed its request");

	property p_sync_delay;
		!$past(srst) && !$past(srst, 2) && !$past(sleep_clamp, 2)
			|-> pin_val == $past(pad_in, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("synchroniser delay wrong");

	property p_rst_clear;
		$past(srst) |-> dir_all == '0 && out_all == '0;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("port registers not cleared by reset");

	c_toggle: cover property (bus.wr && bus.addr == `ADDR_PIN_B ##1 1'b1);
	c_req0: cover property (pc_req[0]);
	c_req1_req2: cover property (pc_req[1] ##1 pc_req[2]);
	c_pud: cover property (global_pullup_disable && dir_pins == '0 && out_pins != '0);

endmodule : gpio_port_top

// >>> dv/gpio_board_model.sv
`timescale 1ns/1ps

module gpio_board_model import gpio_pkg::*; (
	input wire logic clk, // system clock
	input wire pins_t pad_out, // device drive level
	input wire pins_t pad_oe, // device drive enable
	input wire pins_t pad_pullup, // device pull-up enable
	input wire pins_t ext_drv, // board drive level
	input wire pins_t ext_en, // board drive enable
	output pins_t pad_in // resolved pin level
);
	logic flt = 1'b0;

	// undriven pins wander so a stale level is never trusted
	always @(posedge clk) begin
		flt <= ~flt;
	end

	always_comb begin
		for (int i = 0; i < 23; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_drv[i];
			else if (pad_pullup[i])
				pad_in[i] = 1'b1;
			else
				pad_in[i] = flt;
		end
	end
endmodule : gpio_board_model

// >>> dv/gpio_port_with_pin_change_masks_tb_top.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_port_with_pin_change_masks_tb_top import gpio_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sleep_clamp = 1'b0;
	bus_req_s bus = '0;
	alt_ovr_s alt = '0;
	pins_t ext_drv = '0;
	pins_t ext_en = '1;
	byte_t rdata;
	pins_t pad_in;
	pins_t pad_out;
	pins_t pad_oe;
	pins_t pad_pullup;
	logic [2:0] pc_req;
	int n_mismatch = 0;
	int samples_checked = 0;
	byte_t dir_b;

	always #5 clk = ~clk;

	gpio_port_top i_gpio_port_top (.clk(clk), .srst(srst), .bus(bus),
		.rdata(rdata), .pad_in(pad_in), .sleep_clamp(sleep_clamp),
		.alt(alt), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .pc_req(pc_req));

	gpio_board_model i_gpio_board_model (.clk(clk), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_drv(ext_drv),
		.ext_en(ext_en), .pad_in(pad_in));

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task automatic chk(string n, pins_t e, pins_t g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(byte_t a, bit_op_e op, byte_t d);
		@(posedge clk);
		bus.wr <= 1'b1;
		bus.op <= op;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(byte_t a, byte_t e);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, rdata);
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	// toggles one board pin; a request must come three edges later if e is set, and none if e is clear
	task automatic chg(int p, int g, logic e);
		int at;
		at = 0;
		@(posedge clk);
		ext_drv[p] <= ~ext_drv[p];
		for (int k = 1; k <= 6; k++) begin
			@(posedge clk);
			#1;
			if (pc_req[g] === 1'b1 && at == 0)
				at = k;
		end
		chk("pc_req edge", e ? 3 : 0, at);
	endtask : chg

	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		dir_b = `ADDR_OUT_B - 8'h01;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd(dir_b, 8'h00);
		rd(`ADDR_OUT_B, 8'h00);
		rd(`ADDR_MASK0, 8'h00);
		rd(`ADDR_MASK1, 8'h00);
		rd(`ADDR_MASK2, 8'h00);
		wr(`ADDR_MASK0, OP_BYTE, 8'ha5);
		wr(`ADDR_MASK1, OP_BYTE, 8'hff);
		wr(`ADDR_MASK2, OP_BYTE, 8'h5a);
		wr(8'h30, OP_BYTE, 8'hff);
		rd(`ADDR_MASK0, 8'ha5);
		rd(`ADDR_MASK1, 8'h7f);
		rd(`ADDR_MASK2, 8'h5a);
		rd(8'h30, 8'h00);
		$display("test registers done");
		wr(dir_b, OP_BYTE, 8'h0f);
		wr(`ADDR_OUT_B, OP_BYTE, 8'hff);
		settle();
		chk("pad_oe", 8'h0f, pad_oe[7:0]);
		chk("pad_out", 8'h0f, pad_out[7:0] & pad_oe[7:0]);
		chk("pad_pullup", 8'hf0, pad_pullup[7:0]);
		wr(dir_b, OP_SET, 8'h05);
		wr(`ADDR_OUT_B, OP_CLR, 8'h01);
		rd(dir_b, 8'h2f);
		rd(`ADDR_OUT_B, 8'hfd);
		wr(`ADDR_PIN_B, OP_BYTE, 8'h81);
		wr(`ADDR_PIN_B, OP_SET, 8'h00);
		wr(`ADDR_PIN_B, OP_CLR, 8'h02);
		rd(`ADDR_OUT_B, 8'h7d);
		$display("test port done");
		ext_en <= ~23'h000050;
		settle();
		rd(`ADDR_PIN_B, 8'h7d);
		ext_en <= '1;
		wr(`ADDR_MCU_CTRL, OP_BYTE, 8'h10);
		settle();
		chk("pad_pullup all", '0, pad_pullup);
		rd(`ADDR_MCU_CTRL, 8'h10);
		wr(`ADDR_MCU_CTRL, OP_BYTE, 8'h00);
		sleep_clamp <= 1'b1;
		settle();
		rd(`ADDR_PIN_B, 8'h00);
		sleep_clamp <= 1'b0;
		settle();
		$display("test pins done");
		wr(`ADDR_CHG_CTRL, OP_BYTE, 8'h07);
		settle();
		chg(7, 0, 1'b1);
		chg(8, 1, 1'b1);
		chg(16, 2, 1'b1);
		chg(6, 0, 1'b0);
		chg(15, 2, 1'b0);
		wr(`ADDR_CHG_CTRL, OP_BYTE, 8'h05);
		chg(8, 1, 1'b0);
		$display("test change done");
		alt.en[7] <= 1'b1;
		alt.oe[7] <= 1'b1;
		alt.out[7] <= 1'b1;
		settle();
		chk("pad_oe alt", 8'haf, pad_oe[7:0]);
		$display("test alternate done");
		@(posedge clk);
		srst <= 1'b1;
		#1;
		chk("pad_oe reset", '0, pad_oe);
		chk("pad_pullup reset", '0, pad_pullup);
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(dir_b, 8'h00);
		$display("test reset done");
		report_and_stop();
	end
endmodule : gpio_port_with_pin_change_masks_tb_top
